//--- src/acr_cal_if.sv
// Calibration coefficients passed from the register bank to the capture.
`timescale 1ns/1ps
interface acr_cal_if;
    logic [15:0] offset [3];
    logic [15:0] gain [3];
    modport bank
    (
        output offset,
        output gain
    );
    modport capture
    (
        input offset,
        input gain
    );
endinterface

//--- src/acr_calib_apply.sv
// Offset subtraction and gain scaling of one raw converter result.
`timescale 1ns/1ps
module acr_calib_apply
    import acr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Raw result in.
    input wire logic rawValid,
    input wire acr_pkg::acr_chan_t rawChan,
    input wire logic [15:0] rawData,
    // Coefficients.
    acr_cal_if.capture cal,
    // Corrected result out, one cycle later.
    output logic outValid,
    output acr_pkg::acr_chan_t outChan,
    output logic [15:0] outData
);
    logic [1:0] idx;
    logic signed [16:0] diff;
    logic signed [33:0] prod;
    logic signed [33:0] scaled;

    always_comb
    begin
        case (rawChan)
            ACR_CH_VOLT: idx = 2'd1;
            ACR_CH_TEMP: idx = 2'd2;
            default: idx = 2'd0;
        endcase
    end

    // Gain is unsigned with 0x8000 as unity; the result clamps to 16 bits.
    assign diff = $signed({rawData[15], rawData}) -
        $signed({cal.offset[idx][15], cal.offset[idx]});
    assign prod = 34'(diff) * $signed({18'h0, cal.gain[idx]});
    assign scaled = prod >>> 15;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            outValid <= 1'b0;
            outChan <= ACR_CH_CUR;
            outData <= 16'h0000;
        end
        else
        begin
            outValid <= rawValid;
            outChan <= rawChan;
            if (scaled > 34'sh7fff)
                outData <= 16'h7fff;
            else if (scaled < -34'sh8000)
                outData <= 16'h8000;
            else
                outData <= scaled[15:0];
        end
    end
endmodule

//--- src/acr_defs.svh
// Register offsets, field positions, reset values and modulator clock rates.
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
`define ACR_ADDR_W 32
`define ACR_OFS_CUR_RESULT 32'hffff0520
`define ACR_OFS_VT_RESULT 32'hffff0524
`define ACR_OFS_CUR_OFFSET 32'hffff0530
`define ACR_OFS_VOLT_OFFSET 32'hffff0534
`define ACR_OFS_TEMP_OFFSET 32'hffff0538
`define ACR_OFS_CUR_GAIN 32'hffff053c
`define ACR_OFS_VOLT_GAIN 32'hffff0540
`define ACR_OFS_TEMP_GAIN 32'hffff0544
`define ACR_OFS_COUNT_LIMIT 32'hffff0548
`define ACR_OFS_COUNT_VALUE 32'hffff054c
`define ACR_OFS_THRESHOLD 32'hffff0550
`define ACR_OFS_ACCUM 32'hffff055c
`define ACR_OFS_STATUS 32'hffff0500
`define ACR_OFS_EXT_CFG 32'hffff051c
`define ACR_OFS_FILTER 32'hffff0504
`define ACR_OFS_MODE 32'hffff0508
`define ACR_OFS_CUR_CTRL 32'hffff050c
`define ACR_RST_COUNT_LIMIT 16'h0001
`define ACR_RST_FILTER 16'h0007
`define ACR_RST_EXT_CFG 8'h00
`define ACR_RST_OFFSET 16'h0000
`define ACR_RST_GAIN 16'h5555
`define ACR_STA_CUR_RDY 0
`define ACR_STA_VOLT_RDY 1
`define ACR_STA_TEMP_RDY 2
`define ACR_STA_AUX_RDY 5
`define ACR_CFG_CNT_EN 0
`define ACR_CFG_CMP_EN 3
`define ACR_CFG_ACC_EN 4
`define ACR_FLT_DEC_LSB 0
`define ACR_FLT_DEC_MSB 6
`define ACR_FLT_SECOND_NOTCH 7
`define ACR_FLT_AVG_LSB 8
`define ACR_FLT_AVG_MSB 13
`define ACR_FLT_CHOP 15
`define ACR_MODE_LOW_POWER 3
`define ACR_MOD_CLK_NORMAL_KHZ 512
`define ACR_MOD_CLK_LOW_KHZ 128
`endif

//--- src/acr_pkg.sv
// Types shared by the register bank and its result capture helper.
package acr_pkg;
    typedef logic [15:0] acr_word_t;
    typedef enum logic [2:0]
    {
        ACR_CH_CUR = 3'b001,
        ACR_CH_VOLT = 3'b010,
        ACR_CH_TEMP = 3'b100
    } acr_chan_t;
endpackage

//--- src/adc_result_regs.sv
// Result, calibration, counter, comparator, accumulator and filter registers.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "acr_defs.svh"
module adc_result_regs
(
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Raw results from the converters.
    input wire logic rawValid,
    input wire acr_pkg::acr_chan_t rawChan,
    input wire logic [15:0] rawData,
    // Status from the converter core.
    input wire logic curActive,
    input wire logic bipolarFmt,
    // Filter and mode controls towards the converters.
    output logic [6:0] decimationFactor,
    output logic [5:0] averagingFactor,
    output logic secondNotch,
    output logic chopEnable,
    output logic lowPowerMode,
    output logic [9:0] modClkKhz,
    // Events towards the interrupt controller.
    output logic curResultIrq,
    output logic compareIrq
);
    import acr_pkg::*;

    acr_cal_if cal();
    logic calValid;
    acr_chan_t calChan;
    logic [15:0] calData;

    logic [15:0] curResult_reg;
    logic [15:0] vtResult_reg;
    logic [7:0] status_reg;
    logic [7:0] extCfg_reg;
    logic [15:0] filter_reg;
    logic [15:0] mode_reg;
    logic [15:0] curCtrl_reg;
    logic [15:0] offset_reg [3];
    logic [15:0] gain_reg [3];
    logic [15:0] countLimit_reg;
    logic [15:0] countValue_reg;
    logic [15:0] threshold_reg;
    logic [31:0] accum_reg;
    logic [31:0] rdata_next;

    logic wrCurCtrl;
    logic wrMode;
    logic rdCurResult;
    logic rdVtResult;
    logic curNew;
    logic vtNew;
    logic countHit;
    logic [15:0] absResult;
    logic [15:0] thrEff;

    acr_calib_apply calib
    (
        .clk(clk),
        .arst_n(arst_n),
        .rawValid(rawValid),
        .rawChan(rawChan),
        .rawData(rawData),
        .cal(cal.capture),
        .outValid(calValid),
        .outChan(calChan),
        .outData(calData)
    );

    assign wrCurCtrl = regWr && (regAddr == `ACR_OFS_CUR_CTRL);
    assign wrMode = regWr && (regAddr == `ACR_OFS_MODE);
    assign rdCurResult = regRd && (regAddr == `ACR_OFS_CUR_RESULT);
    assign rdVtResult = regRd && (regAddr == `ACR_OFS_VT_RESULT);
    assign curNew = calValid && (calChan == ACR_CH_CUR);
    assign vtNew = calValid && (calChan != ACR_CH_CUR);

    // Result registers update only while their ready flags are clear (volt and temp both for the shared one).
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            curResult_reg <= 16'h0000;
        else if (curNew && !status_reg[`ACR_STA_CUR_RDY])
            curResult_reg <= calData;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            vtResult_reg <= 16'h0000;
        else if (vtNew && !status_reg[`ACR_STA_VOLT_RDY]
            && !status_reg[`ACR_STA_TEMP_RDY])
            vtResult_reg <= calData;
    end

    // Ready flags: a new result sets its flag (the current flag only on a count hit while counting), winning over a read clear.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            status_reg <= 8'h00;
        else
        begin
            if (rdCurResult)
            begin
                status_reg[`ACR_STA_CUR_RDY] <= 1'b0;
                status_reg[`ACR_STA_VOLT_RDY] <= 1'b0;
                status_reg[`ACR_STA_TEMP_RDY] <= 1'b0;
                status_reg[`ACR_STA_AUX_RDY] <= 1'b0;
            end
            else if (rdVtResult && !curActive)
            begin
                status_reg[`ACR_STA_VOLT_RDY] <= 1'b0;
                status_reg[`ACR_STA_TEMP_RDY] <= 1'b0;
                status_reg[`ACR_STA_AUX_RDY] <= 1'b0;
            end
            if (curNew && (!extCfg_reg[`ACR_CFG_CNT_EN] || countHit))
                status_reg[`ACR_STA_CUR_RDY] <= 1'b1;
            if (calValid && calChan == ACR_CH_VOLT)
                status_reg[`ACR_STA_VOLT_RDY] <= 1'b1;
            if (calValid && calChan == ACR_CH_TEMP)
                status_reg[`ACR_STA_TEMP_RDY] <= 1'b1;
        end
    end

    // Calibration coefficients, one pair per channel.
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++)
        begin : gen_cal
            localparam logic [31:0] OFS_ADDR =
                `ACR_OFS_CUR_OFFSET + 32'(ch * 4);
            localparam logic [31:0] GAIN_ADDR =
                `ACR_OFS_CUR_GAIN + 32'(ch * 4);
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    offset_reg[ch] <= `ACR_RST_OFFSET;
                else if (regWr && regAddr == OFS_ADDR)
                    offset_reg[ch] <= regWdata[15:0];
            end
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    gain_reg[ch] <= `ACR_RST_GAIN;
                else if (regWr && regAddr == GAIN_ADDR)
                    gain_reg[ch] <= regWdata[15:0];
            end
            assign cal.offset[ch] = offset_reg[ch];
            assign cal.gain[ch] = gain_reg[ch];
        end
    endgenerate

    // Configuration, filter, mode, control, limit and threshold.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            extCfg_reg <= `ACR_RST_EXT_CFG;
            filter_reg <= `ACR_RST_FILTER;
            mode_reg <= 16'h0000;
            curCtrl_reg <= 16'h0000;
            countLimit_reg <= `ACR_RST_COUNT_LIMIT;
            threshold_reg <= 16'h0000;
        end
        else if (regWr)
        begin
            case (regAddr)
                `ACR_OFS_EXT_CFG: extCfg_reg <= regWdata[7:0];
                `ACR_OFS_FILTER: filter_reg <= regWdata[15:0];
                `ACR_OFS_MODE: mode_reg <= regWdata[15:0];
                `ACR_OFS_CUR_CTRL: curCtrl_reg <= regWdata[15:0];
                `ACR_OFS_COUNT_LIMIT: countLimit_reg <= regWdata[15:0];
                `ACR_OFS_THRESHOLD: threshold_reg <= regWdata[15:0];
                default: ;
            endcase
        end
    end

    // Result counter.
    assign countHit = (countValue_reg + 16'h0001) == countLimit_reg;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            countValue_reg <= 16'h0000;
        else if (wrCurCtrl || wrMode)
            countValue_reg <= 16'h0000;
        else if (curNew && extCfg_reg[`ACR_CFG_CNT_EN])
            countValue_reg <= countHit ? 16'h0000 : countValue_reg + 16'h0001;
    end

    // Comparator on the absolute current result.
    always_comb
    begin
        if (bipolarFmt)
        begin
            absResult = calData[15] ? 16'(-calData) : calData;
            thrEff = {1'b0, threshold_reg[14:0]};
        end
        else
        begin
            absResult = calData;
            thrEff = threshold_reg;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            compareIrq <= 1'b0;
        else
            compareIrq <= curNew && extCfg_reg[`ACR_CFG_CMP_EN]
                && (absResult >= thrEff);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            curResultIrq <= 1'b0;
        else
            curResultIrq <= curNew
                && (!extCfg_reg[`ACR_CFG_CNT_EN] || countHit);
    end

    // Accumulator.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            accum_reg <= 32'h00000000;
        else if (!extCfg_reg[`ACR_CFG_ACC_EN] || wrCurCtrl
            || wrMode)
            accum_reg <= 32'h00000000;
        else if (curNew)
            accum_reg <= accum_reg + {{16{calData[15]}}, calData};
    end

    // Filter and mode fields towards the converters.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            decimationFactor <= 7'h07;
            averagingFactor <= 6'h00;
            secondNotch <= 1'b0;
            chopEnable <= 1'b0;
            lowPowerMode <= 1'b0;
            modClkKhz <= 10'(`ACR_MOD_CLK_NORMAL_KHZ);
        end
        else
        begin
            decimationFactor <=
                filter_reg[`ACR_FLT_DEC_MSB:`ACR_FLT_DEC_LSB];
            averagingFactor <=
                filter_reg[`ACR_FLT_AVG_MSB:`ACR_FLT_AVG_LSB];
            secondNotch <= filter_reg[`ACR_FLT_SECOND_NOTCH];
            chopEnable <= filter_reg[`ACR_FLT_CHOP];
            lowPowerMode <= mode_reg[`ACR_MODE_LOW_POWER];
            modClkKhz <= mode_reg[`ACR_MODE_LOW_POWER]
                ? 10'(`ACR_MOD_CLK_LOW_KHZ)
                : 10'(`ACR_MOD_CLK_NORMAL_KHZ);
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb
    begin
        case (regAddr)
            `ACR_OFS_CUR_RESULT: rdata_next = {16'h0000, curResult_reg};
            `ACR_OFS_VT_RESULT: rdata_next = {16'h0000, vtResult_reg};
            `ACR_OFS_CUR_OFFSET: rdata_next = {16'h0000, offset_reg[0]};
            `ACR_OFS_VOLT_OFFSET: rdata_next = {16'h0000, offset_reg[1]};
            `ACR_OFS_TEMP_OFFSET: rdata_next = {16'h0000, offset_reg[2]};
            `ACR_OFS_CUR_GAIN: rdata_next = {16'h0000, gain_reg[0]};
            `ACR_OFS_VOLT_GAIN: rdata_next = {16'h0000, gain_reg[1]};
            `ACR_OFS_TEMP_GAIN: rdata_next = {16'h0000, gain_reg[2]};
            `ACR_OFS_COUNT_LIMIT: rdata_next = {16'h0000, countLimit_reg};
            `ACR_OFS_COUNT_VALUE: rdata_next = {16'h0000, countValue_reg};
            `ACR_OFS_THRESHOLD: rdata_next = {16'h0000, threshold_reg};
            `ACR_OFS_ACCUM: rdata_next = accum_reg;
            `ACR_OFS_STATUS: rdata_next = {24'h000000, status_reg};
            `ACR_OFS_EXT_CFG: rdata_next = {24'h000000, extCfg_reg};
            `ACR_OFS_FILTER: rdata_next = {16'h0000, filter_reg};
            `ACR_OFS_MODE: rdata_next = {16'h0000, mode_reg};
            `ACR_OFS_CUR_CTRL: rdata_next = {16'h0000, curCtrl_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            regRdata <= 32'h00000000;
        else if (regRd)
            regRdata <= rdata_next;
        else
            regRdata <= 32'h00000000;
    end
endmodule

//--- verification/acr_mcu_model.sv
// Processor bus master that reaches the register bank.
`timescale 1ns/1ps
module acr_mcu_model
(
    // Clock.
    input wire logic clk,
    // Register port.
    output logic [31:0] regAddr,
    output logic [31:0] regWdata,
    output logic regWr,
    output logic regRd,
    input wire logic [31:0] regRdata
);
    initial
    begin
        regAddr = 32'h0;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // Entered just after a rising edge; one edge passes before the next.
    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        regAddr <= addr;
        regWdata <= data;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        regWdata <= ~data;
        @(posedge clk);
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [31:0] addr, output logic [31:0] data);
        regAddr <= addr;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        data = regRdata;
    endtask
endmodule

//--- verification/acr_regs_checker.sv
// Concurrent checks on the ports of the result register bank.
`timescale 1ns/1ps
`include "acr_defs.svh"
module acr_regs_checker
    import acr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // Result path and controls.
    input wire logic rawValid,
    input wire acr_pkg::acr_chan_t rawChan,
    input wire logic [6:0] decimationFactor,
    input wire logic [5:0] averagingFactor,
    input wire logic secondNotch,
    input wire logic chopEnable,
    input wire logic lowPowerMode,
    input wire logic [9:0] modClkKhz,
    input wire logic curResultIrq,
    input wire logic compareIrq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    sequence wr_filter;
        regWr && regAddr == `ACR_OFS_FILTER;
    endsequence
    sequence rd_filter;
        regRd && regAddr == `ACR_OFS_FILTER;
    endsequence
    // No raw result may arrive in the clearing write's cycle or in the two cycles before it.
    sequence quiet;
        !rawValid && !$past(rawValid) && !$past(rawValid, 2);
    endsequence
    // The field outputs are copied from the register one cycle after it.
    chk_filter_fields: assert property (wr_filter |=> ##1
        decimationFactor == $past(regWdata[6:0], 2) &&
        averagingFactor == $past(regWdata[13:8], 2))
        else $error("filter fields wrong");
    chk_filter_flags: assert property (wr_filter |=> ##1
        secondNotch == $past(regWdata[7], 2) &&
        chopEnable == $past(regWdata[15], 2))
        else $error("filter flags wrong");
    chk_filter_read: assert property (rd_filter ##1 !regWr |->
        regRdata[6:0] == decimationFactor && regRdata[7] == secondNotch &&
        regRdata[13:8] == averagingFactor && regRdata[15] == chopEnable)
        else $error("filter read wrong");
    chk_mode_clock: assert property (
        regWr && regAddr == `ACR_OFS_MODE |=> ##1
        lowPowerMode == $past(regWdata[3], 2) &&
        modClkKhz == ($past(regWdata[3], 2) ? 10'h080 : 10'h200))
        else $error("modulator clock wrong");
    chk_cur_irq: assert property (
        curResultIrq |-> $past(rawValid, 2) && $past(rawChan, 2) == ACR_CH_CUR)
        else $error("result event without cause");
    chk_cmp_irq: assert property (
        compareIrq |-> $past(rawValid, 2) && $past(rawChan, 2) == ACR_CH_CUR)
        else $error("compare event without cause");
    chk_count_clear: assert property (
        (regWr && regAddr == `ACR_OFS_CUR_CTRL) ##0 quiet ##2
        (regRd && regAddr == `ACR_OFS_COUNT_VALUE) |=> regRdata == 32'h0)
        else $error("count not cleared");
    chk_accum_clear: assert property (
        (regWr && regAddr == `ACR_OFS_EXT_CFG && !regWdata[4]) ##0 quiet ##2
        (regRd && regAddr == `ACR_OFS_ACCUM) |=> regRdata == 32'h0)
        else $error("accumulator not cleared");
endmodule
bind adc_result_regs acr_regs_checker acr_regs_checker_inst
(
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rawValid(rawValid),
    .rawChan(rawChan), .decimationFactor(decimationFactor),
    .averagingFactor(averagingFactor), .secondNotch(secondNotch),
    .chopEnable(chopEnable), .lowPowerMode(lowPowerMode),
    .modClkKhz(modClkKhz), .curResultIrq(curResultIrq),
    .compareIrq(compareIrq)
);

//--- verification/adc_result_regs_tb.sv
// Self-checking bench for the result register bank.
`timescale 1ns/1ps
`include "acr_defs.svh"
module adc_result_regs_tb;
    import acr_pkg::*;
    logic clk, arst_n, regWr, regRd, rawValid, curActive, bipolarFmt;
    logic secondNotch, chopEnable, lowPowerMode, curResultIrq, compareIrq;
    logic curIrqSeen, cmpIrqSeen;
    logic [31:0] regAddr, regWdata, regRdata;
    logic [15:0] rawData;
    logic [6:0] decimationFactor;
    logic [5:0] averagingFactor;
    logic [9:0] modClkKhz;
    acr_chan_t rawChan;
    int failures;
    int n_tests;
    adc_result_regs adc_result_regs_inst
    (
        .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .rawValid(rawValid), .rawChan(rawChan), .rawData(rawData),
        .curActive(curActive), .bipolarFmt(bipolarFmt),
        .decimationFactor(decimationFactor),
        .averagingFactor(averagingFactor), .secondNotch(secondNotch),
        .chopEnable(chopEnable), .lowPowerMode(lowPowerMode),
        .modClkKhz(modClkKhz), .curResultIrq(curResultIrq),
        .compareIrq(compareIrq)
    );
    acr_mcu_model acr_mcu_model_inst
    (
        .clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata)
    );
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        acr_mcu_model_inst.wr(addr, data);
    endtask
    // Reads a register and compares the bits under the mask.
    task automatic rdm(input logic [31:0] addr, input logic [31:0] mask,
        input logic [31:0] exp);
        logic [31:0] data;
        acr_mcu_model_inst.rd(addr, data);
        check($sformatf("register %h", addr), exp, data & mask);
    endtask
    // Events are sampled in the cycle two edges after the result is taken.
    task automatic send(input acr_chan_t ch, input logic [15:0] d);
        rawChan <= ch;
        rawData <= d;
        rawValid <= 1'b1;
        @(posedge clk);
        rawValid <= 1'b0;
        rawData <= ~d;
        repeat (2) @(posedge clk);
        curIrqSeen = curResultIrq;
        cmpIrqSeen = compareIrq;
    endtask
    task automatic test_reset;
        rdm(`ACR_OFS_FILTER, 32'hffff, 32'h0007);
        rdm(`ACR_OFS_COUNT_LIMIT, 32'hffff, 32'h0001);
        rdm(`ACR_OFS_CUR_GAIN, 32'hffff, 32'h5555);
        rdm(`ACR_OFS_TEMP_OFFSET, 32'hffff, 32'h0000);
        rdm(`ACR_OFS_ACCUM, 32'hffffffff, 32'h0);
        rdm(32'hffff05fc, 32'hffffffff, 32'h0);
        check("decimation", 32'h7, 32'(decimationFactor));
    endtask
    task automatic test_regs;
        for (int i = 0; i < 3; i++)
        begin
            wr(`ACR_OFS_CUR_GAIN + 32'(4 * i), 32'h8000);
            rdm(`ACR_OFS_CUR_GAIN + 32'(4 * i), 32'hffff, 32'h8000);
        end
        wr(`ACR_OFS_VOLT_OFFSET, 32'h0010);
        wr(`ACR_OFS_COUNT_VALUE, 32'h0055);
        rdm(`ACR_OFS_COUNT_VALUE, 32'hffff, 32'h0);
        // Field outputs follow the register one cycle later.
        wr(`ACR_OFS_FILTER, 32'h961f);
        @(posedge clk);
        check("averaging", 32'h16, 32'(averagingFactor));
        check("chop", 32'h1, 32'(chopEnable));
        wr(`ACR_OFS_FILTER, 32'h0087);
        @(posedge clk);
        check("notch", 32'h1, 32'(secondNotch));
        wr(`ACR_OFS_FILTER, 32'h8310);
        rdm(`ACR_OFS_FILTER, 32'hffff, 32'h8310);
        wr(`ACR_OFS_MODE, 32'h8);
        @(posedge clk);
        check("modulator clock", 32'h80, 32'(modClkKhz));
        wr(`ACR_OFS_MODE, 32'h0);
        @(posedge clk);
        check("modulator clock", 32'h200, 32'(modClkKhz));
    endtask
    task automatic test_ready;
        send(ACR_CH_CUR, 16'h1234);
        check("result event", 32'h1, 32'(curIrqSeen));
        send(ACR_CH_CUR, 16'h2222);
        rdm(`ACR_OFS_CUR_RESULT, 32'hffff, 32'h1234);
        rdm(`ACR_OFS_STATUS, 32'h7, 32'h0);
        curActive <= 1'b1;
        send(ACR_CH_VOLT, 16'h0110);
        rdm(`ACR_OFS_VT_RESULT, 32'hffff, 32'h0100);
        rdm(`ACR_OFS_STATUS, 32'h7, 32'h2);
        send(ACR_CH_VOLT, 16'h0210);
        curActive <= 1'b0;
        rdm(`ACR_OFS_VT_RESULT, 32'hffff, 32'h0100);
        rdm(`ACR_OFS_STATUS, 32'h7, 32'h0);
        send(ACR_CH_TEMP, 16'h0300);
        send(ACR_CH_CUR, 16'h0042);
        rdm(`ACR_OFS_CUR_RESULT, 32'hffff, 32'h0042);
        rdm(`ACR_OFS_STATUS, 32'h7, 32'h0);
        rdm(`ACR_OFS_VT_RESULT, 32'hffff, 32'h0300);
    endtask
    task automatic test_count;
        wr(`ACR_OFS_EXT_CFG, 32'h01);
        wr(`ACR_OFS_COUNT_LIMIT, 32'h0003);
        for (int i = 0; i < 4; i++)
        begin
            send(ACR_CH_CUR, 16'h0011);
            check("count event", 32'(i == 2), 32'(curIrqSeen));
            rdm(`ACR_OFS_COUNT_VALUE, 32'hffff, 32'((i + 1) % 3));
            rdm(`ACR_OFS_CUR_RESULT, 32'hffff, 32'h0011);
        end
        wr(`ACR_OFS_CUR_CTRL, 32'h0);
        rdm(`ACR_OFS_COUNT_VALUE, 32'hffff, 32'h0);
        send(ACR_CH_CUR, 16'h0011);
        rdm(`ACR_OFS_COUNT_VALUE, 32'hffff, 32'h1);
        wr(`ACR_OFS_MODE, 32'h0);
        rdm(`ACR_OFS_COUNT_VALUE, 32'hffff, 32'h0);
    endtask
    task automatic test_compare;
        logic [15:0] th [5] = '{16'h0100, 16'h0100, 16'h8100, 16'h0100,
            16'h8100};
        logic [15:0] raw [5] = '{16'hff00, 16'h00ff, 16'h0100, 16'hff00,
            16'h80ff};
        // The last case is unipolar, where threshold bit 15 counts.
        for (int i = 0; i < 5; i++)
        begin
            bipolarFmt <= (i != 4);
            wr(`ACR_OFS_EXT_CFG, (i == 3) ? 32'h0 : 32'h8);
            wr(`ACR_OFS_THRESHOLD, {16'h0, th[i]});
            send(ACR_CH_CUR, raw[i]);
            check("compare event", 32'(i == 0 || i == 2),
                32'(cmpIrqSeen));
            rdm(`ACR_OFS_CUR_RESULT, 32'hffff, {16'h0, raw[i]});
        end
    endtask
    task automatic test_accum;
        wr(`ACR_OFS_EXT_CFG, 32'h10);
        send(ACR_CH_CUR, 16'h7fff);
        rdm(`ACR_OFS_CUR_RESULT, 32'hffff, 32'h7fff);
        send(ACR_CH_CUR, 16'h0001);
        rdm(`ACR_OFS_STATUS, 32'h1, 32'h1);
        rdm(`ACR_OFS_ACCUM, 32'hffffffff, 32'h8000);
        rdm(`ACR_OFS_CUR_RESULT, 32'hffff, 32'h0001);
        send(ACR_CH_CUR, 16'hfff0);
        rdm(`ACR_OFS_ACCUM, 32'hffffffff, 32'h7ff0);
        rdm(`ACR_OFS_CUR_RESULT, 32'hffff, 32'hfff0);
        wr(`ACR_OFS_CUR_CTRL, 32'h0);
        rdm(`ACR_OFS_ACCUM, 32'hffffffff, 32'h0);
        send(ACR_CH_CUR, 16'h0005);
        rdm(`ACR_OFS_ACCUM, 32'hffffffff, 32'h5);
        wr(`ACR_OFS_EXT_CFG, 32'h0);
        rdm(`ACR_OFS_ACCUM, 32'hffffffff, 32'h0);
    endtask
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        arst_n = 1'b0;
        rawValid = 1'b0;
        rawChan = ACR_CH_CUR;
        rawData = 16'h0;
        curActive = 1'b0;
        bipolarFmt = 1'b0;
        failures = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        test_reset;
        test_regs;
        test_ready;
        test_count;
        test_compare;
        test_accum;
        stop_test;
    end
    // The tests need well under a thousand cycles; this cuts a hang short.
    initial
    begin
        #50000;
        failures++;
        stop_test;
    end
endmodule
